// ===== dv/fci_flash_host_monitor.sv
/*
  Concurrent checks on the pins and register port of the flash host.
  Assumes one clock domain and the pin timing constants of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module fci_flash_host_monitor
  import fci_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic              clk_sys_in,             // Clock.
  input wire logic              arst_n_in,              // Reset.
  input wire logic              reg_rd_in,              // Read strobe.
  input wire logic [31:0]       reg_rdata_out,          // Read data.
  input wire logic [ADDR_W-1:0] flash_addr_out,         // Address pins.
  input wire logic              flash_ce_n_out,         // Chip enable.
  input wire logic              flash_oe_n_out,         // Output enable.
  input wire logic              flash_we_n_out,         // Write enable.
  input wire logic [7:0]        flash_dq_out,           // Data to flash.
  input wire logic              flash_dq_oe_out,        // Data drive.
  input wire logic              ready_busy_n_in,        // Flash ready.
  input wire logic              powerdown_unlock_n_out  // Power-down pin.
);
  logic [7:0] oe_low_cnt;

  // A counter measures the read pulse, which is too long for a repetition.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oe_low_cnt <= 8'h00;
    end else begin
      oe_low_cnt <= flash_oe_n_out ? 8'h00 : oe_low_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  sequence seq_write_pulse;
    !flash_we_n_out [*7] ##1 flash_we_n_out;
  endsequence
  sequence seq_recover;
    flash_ce_n_out [*4];
  endsequence

  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its answer cycle");
  chk_strobe_excl: assert property (flash_oe_n_out || flash_we_n_out)
    else $error("read and write strobes low together");
  chk_write_drive: assert property (!flash_we_n_out |-> flash_dq_oe_out && !flash_ce_n_out)
    else $error("write strobe without data drive");
  chk_read_release: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && !flash_ce_n_out)
    else $error("data driven during a read");
  chk_write_stable: assert property (!flash_we_n_out && !$past(flash_we_n_out)
    |-> $stable(flash_dq_out) && $stable(flash_addr_out))
    else $error("byte or address moved during write");
  chk_write_pulse: assert property ($fell(flash_we_n_out) |-> seq_write_pulse)
    else $error("write pulse length wrong");
  chk_read_pulse: assert property ($rose(flash_oe_n_out) |-> oe_low_cnt == READ_ACCESS_CYC)
    else $error("read pulse length wrong");
  chk_ce_recover: assert property ($rose(flash_ce_n_out) |-> seq_recover)
    else $error("chip enable recovery too short");
  chk_pd_idle: assert property (!powerdown_unlock_n_out |-> flash_ce_n_out)
    else $error("bus cycle during power-down");
  chk_busy_nowrite: assert property ($fell(flash_we_n_out) && flash_dq_out == CMD_READ_ARRAY
    |-> ready_busy_n_in)
    else $error("read array while busy");
endmodule

bind fci_flash_host fci_flash_host_monitor #(.ADDR_W(ADDR_W)) i_mon (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .flash_addr_out(flash_addr_out), .flash_ce_n_out(flash_ce_n_out),
  .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out), .ready_busy_n_in(ready_busy_n_in),
  .powerdown_unlock_n_out(powerdown_unlock_n_out)
);
`default_nettype wire

// ===== dv/fci_flash_model.sv
/*
  Behavioural byte-wide flash: command decoder, status, identifier and a
  small array. Assumes pins are sampled on the host's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fci_flash_model
  import fci_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value.
  parameter logic [7:0] DEV_CODE = 8'h5D, // Arbitrary value.
  parameter int         BUSY_CYC = 40
) (
  input  wire logic        clk_in,     // Host clock.
  input  wire logic        ce_n_in,    // Chip enable.
  input  wire logic        oe_n_in,    // Output enable.
  input  wire logic        we_n_in,    // Write enable.
  input  wire logic [23:0] addr_in,    // Address.
  input  wire logic [7:0]  dq_in,      // Byte from host.
  input  wire logic        pd_n_in,    // Low is power-down.
  input  wire logic        elev_in,    // Elevated unlock level.
  input  wire logic        vpp_low_in, // Supply at lockout.
  output logic [7:0]       dq_out,     // Byte to host.
  output logic             rb_n_out    // Low while busy.
);
  logic [7:0] mem [16];
  logic [7:0] sr, pend, q;
  logic [3:0] idx;
  logic       blk, we_q, rd_q;
  fci_mode_e  mode = MODE_ARRAY;
  int         busy = 0;

  assign blk = addr_in[16];
  assign idx = {addr_in[16], addr_in[2:0]};
  assign rb_n_out = (busy == 0);
  // A released bus shows the inverse, never a stale byte.
  assign dq_out = rd_q ? ~q : q;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'h30 + 8'(i);
    {sr, pend, q} = '0;
    {we_q, rd_q} = 2'h3;
  end

  always @(posedge clk_in) begin
    we_q <= we_n_in;
    rd_q <= oe_n_in | ce_n_in;
    if (busy > 0) busy <= busy - 1;
    if (!pd_n_in) begin
      mode <= MODE_ARRAY;
      busy <= 0;
      pend <= 8'h00;
    end else if (we_n_in && !we_q && busy == 0) begin
      pend <= 8'h00;
      if (pend == CMD_ERASE_SETUP) begin
        mode <= MODE_STATUS;
        if (dq_in != CMD_ERASE_CONFIRM) sr <= sr | 8'h30;
        else if (vpp_low_in) sr <= sr | 8'h28;
        else if (blk && !elev_in) sr <= sr | 8'h22;
        else begin
          for (int i = 0; i < 8; i++) mem[{blk, 3'(i)}] <= 8'hFF;
          busy <= BUSY_CYC;
        end
      end else if (pend == CMD_PROGRAM_SETUP || pend == CMD_PROGRAM_SETUP_ALT) begin
        mode <= MODE_STATUS;
        if (vpp_low_in) sr <= sr | 8'h28;
        else if (blk && !elev_in) sr <= sr | 8'h12;
        else begin
          mem[idx] <= mem[idx] & dq_in;
          busy <= BUSY_CYC;
        end
      end else begin
        case (dq_in)
          CMD_READ_ARRAY: mode <= MODE_ARRAY;
          CMD_READ_ID: mode <= MODE_ID;
          CMD_READ_STATUS: mode <= MODE_STATUS;
          CMD_CLEAR_STATUS: sr <= sr & 8'hC5;
          CMD_ERASE_SETUP, CMD_PROGRAM_SETUP, CMD_PROGRAM_SETUP_ALT: begin
            pend <= dq_in;
            mode <= MODE_STATUS;
          end
          default: ;
        endcase
      end
    end
    if (!(oe_n_in | ce_n_in) && rd_q) begin
      case (mode)
        MODE_ARRAY: q <= mem[idx];
        MODE_ID: q <= (addr_in[1:0] == 2'h0) ? MFR_CODE : (addr_in[1:0] == 2'h1) ? DEV_CODE :
                      {7'h00, addr_in[1:0] == 2'h2 && blk};
        default: q <= {busy == 0, sr[6:0]};
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_fci_flash_host.sv
/*
  Self-checking bench for the flash host: register port tasks, reset checks,
  a table of operations against the flash model, then power-down cases.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fci_flash_host;
  import fci_pkg::*;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value.
  localparam logic [7:0] DEV = 8'h5D; // Arbitrary value.
  typedef struct packed {
    logic [1:0]  ctl;
    logic        vpp;
    logic [2:0]  op;
    logic [23:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } fci_row_s;

  logic        clk_sys_in, arst_n_in, reg_wr, reg_rd, ce_n, oe_n, we_n, dq_oe, rb_n, pd_n, elev, vpp_low;
  logic [7:0]  reg_addr, dq_o, dq_i;
  logic [31:0] reg_wdata, reg_rdata, rq;
  logic [23:0] flash_addr;
  int          errors = 0;
  int          cmp_count = 0;
  fci_row_s    rows [25] = '{
    '{2'h0, 1'h0, 3'h0, 24'h000004, 8'h00, 8'h34}, '{2'h0, 1'h0, 3'h6, 24'h000005, 8'h00, 8'h35},
    '{2'h0, 1'h0, 3'h1, 24'h000000, 8'h00, MFR},   '{2'h0, 1'h0, 3'h6, 24'h000001, 8'h00, DEV},
    '{2'h0, 1'h0, 3'h6, 24'h010002, 8'h00, 8'h01}, '{2'h0, 1'h0, 3'h6, 24'h000002, 8'h00, 8'h00},
    '{2'h0, 1'h0, 3'h6, 24'h000003, 8'h00, 8'h00}, '{2'h0, 1'h0, 3'h2, 24'h000000, 8'h00, 8'h80},
    '{2'h0, 1'h0, 3'h5, 24'h000004, 8'h5A, 8'h80}, '{2'h0, 1'h0, 3'h0, 24'h000004, 8'h00, 8'h10},
    '{2'h0, 1'h0, 3'h5, 24'h000004, 8'hFF, 8'h80}, '{2'h0, 1'h0, 3'h0, 24'h000004, 8'h00, 8'h10},
    '{2'h0, 1'h0, 3'h4, 24'h000007, 8'h00, 8'h80}, '{2'h0, 1'h0, 3'h0, 24'h000004, 8'h00, 8'hFF},
    '{2'h0, 1'h0, 3'h4, 24'h010001, 8'h00, 8'hA2}, '{2'h0, 1'h0, 3'h6, 24'h010001, 8'h00, 8'hA2},
    '{2'h0, 1'h0, 3'h0, 24'h010001, 8'h00, 8'h39}, '{2'h0, 1'h0, 3'h3, 24'h000000, 8'h00, 8'h39},
    '{2'h0, 1'h0, 3'h2, 24'h000000, 8'h00, 8'h80}, '{2'h2, 1'h0, 3'h4, 24'h010001, 8'h00, 8'h80},
    '{2'h2, 1'h0, 3'h0, 24'h010001, 8'h00, 8'hFF}, '{2'h0, 1'h1, 3'h5, 24'h000004, 8'h00, 8'hA8},
    '{2'h0, 1'h1, 3'h0, 24'h000004, 8'h00, 8'hFF}, '{2'h0, 1'h1, 3'h3, 24'h000000, 8'h00, 8'hFF},
    '{2'h0, 1'h1, 3'h4, 24'h000004, 8'h00, 8'hA8}};

  fci_flash_host #(.ADDR_W(24)) i_dut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .flash_addr_out(flash_addr),
    .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_dq_out(dq_o),
    .flash_dq_oe_out(dq_oe), .flash_dq_in(dq_i), .ready_busy_n_in(rb_n),
    .powerdown_unlock_n_out(pd_n), .elevated_unlock_out(elev));
  fci_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .BUSY_CYC(40)) i_flash (
    .clk_in(clk_sys_in), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(flash_addr),
    .dq_in(dq_o), .pd_n_in(pd_n), .elev_in(elev), .vpp_low_in(vpp_low), .dq_out(dq_i), .rb_n_out(rb_n));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic conclude();
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 rq = reg_rdata;
  endtask

  // Polls the busy flag with a bound so a stuck sequence cannot hang the run.
  task automatic run(input logic [2:0] op);
    int n = 0;
    wr(REG_COMMAND, {29'h0, op});
    do begin
      rd(REG_STATE);
      n++;
    end while (rq[STATE_BUSY_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      errors++;
      $display("ERROR %0t: operation never finished", $time);
    end
  endtask

  initial begin
    {arst_n_in, reg_wr, reg_rd, vpp_low, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    rd(REG_STATE);
    chk(rq, 32'h2);
    rd(REG_CONTROL);
    chk(rq, 32'h0);
    rd(8'h20);
    chk(rq, 32'h0);
    foreach (rows[i]) begin
      wr(REG_CONTROL, {30'h0, rows[i].ctl});
      wr(REG_ADDRESS, {8'h00, rows[i].a});
      wr(REG_WDATA, {24'h0, rows[i].d});
      vpp_low <= rows[i].vpp;
      run(rows[i].op);
      rd(REG_RESULT);
      chk(rq, {24'h0, rows[i].e});
    end
    rd(REG_STATE);
    chk(rq, 32'h26);
    vpp_low <= 1'b0;
    run(3'h1);
    wr(REG_CONTROL, 32'h1);
    wr(REG_COMMAND, 32'h1);
    chk({31'h0, pd_n}, 32'h0);
    wr(REG_CONTROL, 32'h0);
    rd(REG_STATE);
    chk(rq, 32'h6);
    run(3'h6);
    rd(REG_RESULT);
    chk(rq, 32'hFF);
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire

// ===== hw/fci_cycle_engine.sv
/*
  One asynchronous flash bus cycle, read or write, timed in system clocks.
  Assumes the caller starts a cycle only while the engine is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module fci_cycle_engine
  import fci_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_sys_in,  // System clock.
  input  wire logic              arst_n_in,   // Asynchronous reset, active low.
  input  wire logic              start_in,    // Start a cycle, one-cycle pulse.
  input  wire fci_req_s          req_in,      // Direction and write byte.
  input  wire logic [ADDR_W-1:0] addr_in,     // Cycle address.
  input  wire logic [7:0]        dq_in,       // Data from the flash.
  output logic                   done_out,    // Cycle finished, one-cycle pulse.
  output logic [7:0]             rdata_out,   // Byte sampled by a read.
  output fci_pins_s              pins_out,    // Strobes and data drive.
  output logic [ADDR_W-1:0]      addr_out     // Address pins.
);

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_ACTIVE,
    ENG_RECOVER
  } fci_eng_e;

  typedef struct packed {
    fci_eng_e          st;
    logic [7:0]        cnt;
    logic              write;
    logic [7:0]        rdata;
    fci_pins_s         pins;
    logic [ADDR_W-1:0] addr;
  } fci_eng_s;

  fci_eng_s s;
  fci_eng_s next_s;

  always_comb begin
    next_s = s;
    done_out = 1'b0;
    case (s.st)
      ENG_IDLE: begin
        if (start_in) begin
          next_s.st = ENG_ACTIVE;
          next_s.write = req_in.write;
          next_s.addr = addr_in;
          next_s.pins.ce_n = 1'b0;
          next_s.pins.we_n = ~req_in.write;
          next_s.pins.oe_n = req_in.write;
          next_s.pins.dq_oe = req_in.write;
          next_s.pins.dq = req_in.data;
          next_s.cnt = req_in.write ? WRITE_PULSE_CYC - 8'h01 : READ_ACCESS_CYC - 8'h01;
        end
      end
      ENG_ACTIVE: begin
        if (s.cnt == 8'h00) begin
          // The byte is latched by the flash on this rising write strobe, so data stays driven into recovery.
          next_s.pins.ce_n = 1'b1; // RL17
          next_s.pins.we_n = 1'b1;
          // Both strobes return high after every read so the next status read shows fresh contents.
          next_s.pins.oe_n = 1'b1; // RL9
          if (!s.write) begin
            next_s.rdata = dq_in;
          end
          next_s.st = ENG_RECOVER;
          next_s.cnt = RECOVER_CYC - 8'h01;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: begin
        if (s.cnt == 8'h00) begin
          next_s.pins.dq_oe = 1'b0;
          next_s.st = ENG_IDLE;
          done_out = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '{st: ENG_IDLE, cnt: 8'h00, write: 1'b0, rdata: 8'h00,
             pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0, dq: 8'h00},
             addr: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign pins_out = s.pins;
  assign addr_out = s.addr;

endmodule
`default_nettype wire

// ===== hw/fci_flash_host.sv
/*
  Host-side controller for a byte-wide flash with a command decoder and an
  internal write state machine. Software gives orders through a small register
  port; the controller sequences the flash pins and polls for completion.
  Assumes flash pin inputs are synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
module fci_flash_host
  import fci_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_sys_in,             // System clock, 125 MHz.
  input  wire logic              arst_n_in,              // Asynchronous reset, active low.
  input  wire logic [7:0]        reg_addr_in,            // Register byte address.
  input  wire logic [31:0]       reg_wdata_in,           // Register write data.
  input  wire logic              reg_wr_in,              // Register write strobe.
  input  wire logic              reg_rd_in,              // Register read strobe.
  output logic [31:0]            reg_rdata_out,          // Read data, cycle after strobe.
  output logic [ADDR_W-1:0]      flash_addr_out,         // Flash address pins.
  output logic                   flash_ce_n_out,         // Chip enable, active low.
  output logic                   flash_oe_n_out,         // Output enable, active low.
  output logic                   flash_we_n_out,         // Write enable, active low.
  output logic [7:0]             flash_dq_out,           // Data driven to the flash.
  output logic                   flash_dq_oe_out,        // High while driving data.
  input  wire logic [7:0]        flash_dq_in,            // Data from the flash.
  input  wire logic              ready_busy_n_in,        // Flash ready, low while busy.
  output logic                   powerdown_unlock_n_out, // Low puts flash in deep power-down.
  output logic                   elevated_unlock_out     // Requests elevated unlock level.
);

  if (ADDR_W < 17 || ADDR_W > 24) begin : g_addr_check
    $error("ADDR_W must lie between 17 and 24");
  end

  typedef enum logic [2:0] {
    M_IDLE,
    M_WAIT_READY,
    M_WRITE1,
    M_WRITE2,
    M_SETTLE,
    M_POLL,
    M_READ
  } fci_main_e;

  typedef struct packed {
    fci_main_e         st;
    logic [2:0]        op;
    logic              issued;
    logic [7:0]        cnt;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        result;
    logic              error;
    fci_mode_e         mode;
    logic              powerdown;
    logic              elevated;
    logic [31:0]       rdata;
  } fci_main_s;

  fci_main_s  s;
  fci_main_s  next_s;
  logic       eng_start;
  fci_req_s   eng_req;
  logic       eng_done;
  logic [7:0] eng_rdata;
  fci_pins_s  eng_pins;

  function automatic logic [7:0] first_code(input logic [2:0] op);
    // Command codes sent in the first write cycle.
    if (op == OP_READ_ID) begin
      first_code = CMD_READ_ID; // RL23
    end else if (op == OP_READ_STATUS) begin
      first_code = CMD_READ_STATUS;
    end else if (op == OP_CLEAR_STATUS) begin
      first_code = CMD_CLEAR_STATUS; // RL11
    end else if (op == OP_ERASE) begin
      first_code = CMD_ERASE_SETUP; // RL12
    end else if (op == OP_PROGRAM) begin
      first_code = CMD_PROGRAM_SETUP; // RL17
    end else begin
      first_code = CMD_READ_ARRAY;
    end
  endfunction

  function automatic logic two_writes(input logic [2:0] op);
    two_writes = (op == OP_ERASE) || (op == OP_PROGRAM);
  endfunction

  always_comb begin
    next_s = s;
    eng_start = 1'b0;
    eng_req = '{write: 1'b1, data: first_code(s.op)};
    next_s.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      if (reg_addr_in == REG_ADDRESS) begin
        next_s.rdata = 32'(s.addr);
      end else if (reg_addr_in == REG_WDATA) begin
        next_s.rdata = {24'h00_0000, s.wdata};
      end else if (reg_addr_in == REG_RESULT) begin
        next_s.rdata = {24'h00_0000, s.result};
      end else if (reg_addr_in == REG_STATE) begin
        next_s.rdata[STATE_BUSY_BIT] = (s.st != M_IDLE);
        next_s.rdata[STATE_READY_BIT] = ready_busy_n_in;
        next_s.rdata[STATE_ERROR_BIT] = s.error;
        next_s.rdata[STATE_MODE_LSB +: 2] = s.mode;
      end else if (reg_addr_in == REG_CONTROL) begin
        next_s.rdata[CTRL_POWERDOWN_BIT] = s.powerdown;
        next_s.rdata[CTRL_ELEVATED_BIT] = s.elevated;
      end
    end
    if (reg_wr_in) begin
      if (reg_addr_in == REG_ADDRESS && s.st == M_IDLE) begin
        next_s.addr = reg_wdata_in[ADDR_W-1:0];
      end else if (reg_addr_in == REG_WDATA && s.st == M_IDLE) begin
        next_s.wdata = reg_wdata_in[7:0];
      end else if (reg_addr_in == REG_CONTROL && s.st == M_IDLE) begin
        next_s.powerdown = reg_wdata_in[CTRL_POWERDOWN_BIT];
        // The read commands are issued whatever this level is.
        next_s.elevated = reg_wdata_in[CTRL_ELEVATED_BIT]; // RL4 RL16
      end else if (reg_addr_in == REG_COMMAND && s.st == M_IDLE && !s.powerdown
                   && reg_wdata_in[2:0] <= OP_READ) begin
        next_s.op = reg_wdata_in[2:0];
        next_s.st = M_WAIT_READY;
      end
    end
    if (s.powerdown) begin
      // The flash wakes from deep power-down in array mode.
      next_s.mode = MODE_ARRAY; // RL1
    end
    case (s.st)
      M_WAIT_READY: begin
        // Read array is not recognised by a busy flash, and new algorithms must not overlap.
        if (ready_busy_n_in || !(s.op == OP_READ_ARRAY || two_writes(s.op))) begin // RL3 RL22
          next_s.st = (s.op == OP_READ) ? M_READ : M_WRITE1;
        end
      end
      M_WRITE1: begin
        eng_start = !s.issued;
        next_s.issued = 1'b1;
        if (eng_done) begin
          next_s.issued = 1'b0;
          if (two_writes(s.op)) begin
            next_s.st = M_WRITE2;
          end else if (s.op == OP_CLEAR_STATUS) begin
            // Accumulated error flags are gone in the flash, so the local summary goes too.
            next_s.error = 1'b0; // RL10 RL11
            next_s.st = M_IDLE;
          end else if (s.op == OP_READ_ARRAY) begin
            next_s.mode = MODE_ARRAY; // RL2
            next_s.st = M_READ;
          end else if (s.op == OP_READ_ID) begin
            next_s.mode = MODE_ID; // RL5 RL6 RL7
            next_s.st = M_READ;
          end else begin
            next_s.mode = MODE_STATUS; // RL8
            next_s.st = M_READ;
          end
        end
      end
      M_WRITE2: begin
        // The confirm or data write follows the setup directly, so the sequence is never malformed.
        eng_req.data = (s.op == OP_ERASE) ? CMD_ERASE_CONFIRM : s.wdata; // RL14 RL17
        eng_start = !s.issued;
        next_s.issued = 1'b1;
        if (eng_done) begin
          next_s.issued = 1'b0;
          next_s.mode = MODE_STATUS; // RL13 RL18
          next_s.cnt = BUSY_ONSET_CYC;
          next_s.st = M_SETTLE;
        end
      end
      M_SETTLE: begin
        // The busy pin needs time to fall after the last write; polling earlier could see stale ready.
        if (s.cnt == 8'h00) begin
          next_s.st = M_POLL;
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      M_POLL: begin
        if (ready_busy_n_in) begin // RL22
          next_s.st = M_READ;
        end
      end
      M_READ: begin
        eng_req.write = 1'b0;
        eng_start = !s.issued;
        next_s.issued = 1'b1;
        if (eng_done) begin
          next_s.issued = 1'b0;
          next_s.result = eng_rdata;
          next_s.st = M_IDLE;
          if (two_writes(s.op)) begin
            if (!eng_rdata[STATUS_READY_BIT]) begin // RL24
              next_s.st = M_POLL;
            end else begin
              // Sticky summary of every failure the flash reports after an algorithm.
              next_s.error = s.error | eng_rdata[STATUS_ERASE_ERROR_BIT] // RL21 RL15 RL20
                           | eng_rdata[STATUS_PROGRAM_ERROR_BIT]        // RL19
                           | eng_rdata[STATUS_SUPPLY_LOW_BIT]
                           | eng_rdata[STATUS_LOCK_VIOLATION_BIT];
            end
          end
        end
      end
      default: begin
        next_s.issued = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '{st: M_IDLE, op: OP_READ_ARRAY, issued: 1'b0, cnt: 8'h00, addr: '0,
             wdata: 8'h00, result: 8'h00, error: 1'b0, mode: MODE_ARRAY, // RL1
             powerdown: 1'b0, elevated: 1'b0, rdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  fci_cycle_engine #(
    .ADDR_W (ADDR_W)
  ) u_engine (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .start_in   (eng_start),
    .req_in     (eng_req),
    .addr_in    (s.addr),
    .dq_in      (flash_dq_in),
    .done_out   (eng_done),
    .rdata_out  (eng_rdata),
    .pins_out   (eng_pins),
    .addr_out   (flash_addr_out)
  );

  assign reg_rdata_out = s.rdata;
  assign flash_ce_n_out = eng_pins.ce_n;
  assign flash_oe_n_out = eng_pins.oe_n;
  assign flash_we_n_out = eng_pins.we_n;
  assign flash_dq_out = eng_pins.dq;
  assign flash_dq_oe_out = eng_pins.dq_oe;
  assign powerdown_unlock_n_out = ~s.powerdown;
  assign elevated_unlock_out = s.elevated;

endmodule
`default_nettype wire

// ===== hw/fci_pkg.sv
/*
  Constants, command codes, register map and carrier types for the host-side
  flash command controller. Assumes a byte-wide flash part with asynchronous
  chip, output and write strobes, and a 125 MHz system clock.
*/
// Summary of operation
// [RL1] Reset or power-down exit means read array
// [RL2] Array mode persists until another command
// [RL3] Read array ignored while algorithm runs
// [RL4] Read commands work at any supply level
// [RL5] Identifier codes live at addresses 0 to 3
// [RL6] Upper address bits pick block lock code
// [RL7] Identifier mode lasts until next valid command
// [RL8] Status mode returns status on every read
// [RL9] Status latched on strobe fall; return high
// [RL10] Error flags accumulate until clear status
// [RL11] Clear status code 50H clears error flags
// [RL12] Erase one block by setup then confirm
// [RL13] After erase reads return status; poll ready
// [RL14] Bad erase confirm sets bits 4 and 5
// [RL15] Erase at low supply sets bits 3, 5
// [RL16] Locked block erase needs elevated unlock level
// [RL17] Program setup 40H/10H then address and byte
// [RL18] After program reads return status; poll ready
// [RL19] Program verify fails only unflipped ones
// [RL20] Program at low supply sets bits 3, 5
// [RL21] Host checks erase error, clears before recovery
// [RL22] Ready/busy low while algorithm executes
// [RL23] Command codes FF, 90, 70, 20, D0
// [RL24] Status bit 7 mirrors ready/busy pin
package fci_pkg;

  localparam logic [7:0] CMD_READ_ARRAY        = 8'hFF;
  localparam logic [7:0] CMD_READ_ID           = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS       = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS      = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP       = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_PROGRAM_SETUP     = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_SETUP_ALT = 8'h10;

  localparam int STATUS_READY_BIT         = 7;
  localparam int STATUS_ERASE_ERROR_BIT   = 5;
  localparam int STATUS_PROGRAM_ERROR_BIT = 4;
  localparam int STATUS_SUPPLY_LOW_BIT    = 3;
  localparam int STATUS_LOCK_VIOLATION_BIT = 1;

  localparam logic [23:0] ID_MANUFACTURER_ADDR = 24'h000000;
  localparam logic [23:0] ID_DEVICE_ADDR       = 24'h000001;
  localparam logic [15:0] ID_BLOCK_LOCK_LOW    = 16'h0002;
  localparam logic [23:0] ID_MASTER_LOCK_ADDR  = 24'h000003;
  localparam int          ID_LOCK_BIT          = 0;

  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_WDATA   = 8'h08;
  localparam logic [7:0] REG_RESULT  = 8'h0C;
  localparam logic [7:0] REG_STATE   = 8'h10;
  localparam logic [7:0] REG_CONTROL = 8'h14;

  localparam logic [2:0] OP_READ_ARRAY   = 3'h0;
  localparam logic [2:0] OP_READ_ID      = 3'h1;
  localparam logic [2:0] OP_READ_STATUS  = 3'h2;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h3;
  localparam logic [2:0] OP_ERASE        = 3'h4;
  localparam logic [2:0] OP_PROGRAM      = 3'h5;
  localparam logic [2:0] OP_READ         = 3'h6;

  localparam int STATE_BUSY_BIT  = 0;
  localparam int STATE_READY_BIT = 1;
  localparam int STATE_ERROR_BIT = 2;
  localparam int STATE_MODE_LSB  = 4;
  localparam int CTRL_POWERDOWN_BIT = 0;
  localparam int CTRL_ELEVATED_BIT  = 1;

  localparam int CLK_MHZ          = 125;
  localparam int T_WRITE_PULSE_NS = 50;
  localparam int T_READ_ACCESS_NS = 100;
  localparam int T_RECOVER_NS     = 30;
  localparam int T_BUSY_ONSET_NS  = 100;
  localparam logic [7:0] WRITE_PULSE_CYC = 8'((T_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] READ_ACCESS_CYC = 8'((T_READ_ACCESS_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RECOVER_CYC     = 8'((T_RECOVER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] BUSY_ONSET_CYC  = 8'((T_BUSY_ONSET_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {
    MODE_ARRAY,
    MODE_ID,
    MODE_STATUS
  } fci_mode_e;

  typedef struct packed {
    logic       ce_n;
    logic       oe_n;
    logic       we_n;
    logic       dq_oe;
    logic [7:0] dq;
  } fci_pins_s;

  typedef struct packed {
    logic       write;
    logic [7:0] data;
  } fci_req_s;

endpackage
